// >>> verilog/lpwt_pkg.sv
// shared constants, types and helpers of the low-power wake timer
package lpwt_pkg;
    // ------------------------------------------------------------
    // counter geometry
    // ------------------------------------------------------------
    localparam int          CNT_W          = 31;
    localparam int          SLICE_W        = 16;
    localparam int          RES_STEP       = 5;
    localparam logic [30:0] CNT_CLEAR_VAL  = 31'h0000_0004;
    localparam logic [15:0] CMP_RESET      = 16'h876b;
    localparam logic [1:0]  RES_RESET      = 2'h0;
    localparam int          CLEAR_EDGES    = 2;
    localparam int          SLEEP_MIN_PER  = 384;

    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int XOSC_HZ       = 32768;
    localparam int RC_DIV        = 750;
    localparam int F_REF_HZ      = 26_000_000;
    localparam int RC_RAW_HZ     = 30000;
    localparam int ACC_W         = 27;
    localparam int RATE_W        = 16;

    // ------------------------------------------------------------
    // controller register map
    // ------------------------------------------------------------
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_CMP  = 3'h1;
    localparam logic [2:0] REG_TIME = 3'h2;
    localparam logic [2:0] REG_STAT = 3'h3;
    localparam logic [2:0] REG_MASK = 3'h4;
    localparam int CTRL_RES_LSB   = 0;
    localparam int CTRL_OSC_BIT   = 2;
    localparam int CTRL_CLR_BIT   = 3;
    localparam int CTRL_SMODE_LSB = 4;
    localparam int CTRL_SLEEP_BIT = 6;
    localparam int CTRL_BUSY_BIT  = 7;
    localparam int STAT_PEND_BIT  = 0;
    localparam int STAT_CPU_BIT   = 1;
    localparam int STAT_REF_BIT   = 2;
    localparam logic [1:0] SMODE_RESET = 2'h0;
    localparam logic [2:0] MASK_RESET  = 3'h0;

    typedef enum logic [2:0] {
        pm_active, power_mode_zero, power_mode_one, power_mode_two, power_mode_three
    } lpwt_pmode_t;

    // 16-bit window of the counter picked by the resolution
    function automatic logic [15:0] lpwt_slice(input logic [30:0] cnt, input logic [1:0] res);
        logic [30:0] sh;
        sh = cnt >> (RES_STEP * int'(res));
        return sh[15:0];
    endfunction : lpwt_slice

    // slow-clock periods spanned by a mantissa at a resolution
    function automatic logic [30:0] lpwt_span(input logic [15:0] m, input logic [1:0] res);
        return 31'(m) << (RES_STEP * int'(res));
    endfunction : lpwt_span
endpackage : lpwt_pkg

// >>> verilog/lpwt_if.sv
// link between the wake timer and the power-mode controller
`timescale 1ns/1ps
`default_nettype none
interface lpwt_if;
    import lpwt_pkg::*;
    lpwt_pmode_t pmode;
    logic [15:0] wake_compare_value;
    logic [1:0]  res;
    logic        osc_sel;
    logic        cnt_clear;
    logic        xosc_run;
    logic        wake_irq_mask;
    logic        pend_clr;
    logic        cpu_clr;
    logic [15:0] sleep_time;
    logic        slow_tick;
    logic        wake_req;
    logic        wake_pending_flag;
    logic        sleep_cpu_irq_flag;

    modport dev (input pmode, wake_compare_value, res, osc_sel, cnt_clear, xosc_run,
                 wake_irq_mask, pend_clr, cpu_clr,
                 output sleep_time, slow_tick, wake_req, wake_pending_flag,
                 sleep_cpu_irq_flag);
    modport pwr (output pmode, wake_compare_value, res, osc_sel, cnt_clear, xosc_run,
                 wake_irq_mask, pend_clr, cpu_clr,
                 input sleep_time, slow_tick, wake_req, wake_pending_flag,
                 sleep_cpu_irq_flag);
endinterface : lpwt_if
`default_nettype wire

// >>> verilog/lpwt_tick_gen.sv
// fractional divider: one-cycle tick at an average rate of rate hz
`timescale 1ns/1ps
`default_nettype none
module lpwt_tick_gen #(
    parameter int CLK_FREQ = lpwt_pkg::CLK_HZ
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // rate in hz
    input  wire logic [lpwt_pkg::RATE_W-1:0] rate,
    // tick out
    output logic                            tick
);
    import lpwt_pkg::*;

    localparam logic [ACC_W-1:0] MODV = ACC_W'(CLK_FREQ);

    logic [ACC_W-1:0] acc_q, acc_d;
    logic             tick_q, tick_d;

    // phase accumulator; jitter is one fast cycle, far below a slow period
    always_comb begin
        acc_d  = acc_q + ACC_W'(rate);
        tick_d = 1'b0;
        if (acc_d >= MODV) begin
            acc_d  = acc_d - MODV;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule : lpwt_tick_gen
`default_nettype wire

// >>> verilog/lpwt_timer.sv
// wake timer end: 31-bit slow counter, compare event, rc calibration
//
// What this block does
// RULE1: 31-bit counter, one step per slow period
// RULE2: resolution picks bits 15:0, 20:5, 25:10, 30:15
// RULE3: slow clock is crystal or rc at fref/750
// RULE4: wake only in power modes zero to two
// RULE5: slice equal compare wakes chip to active
// RULE6: interval is mantissa times two to 5*res
// RULE7: sleep entry leaves at least 384 periods; code checks this on pm2 entry only
// RULE8: compare update and sleep aligned to tick
// RULE9: time readout low byte follows selected slice
// RULE10: lowering compare below count needs clear first
// RULE11: two slow edges after clear before use
// RULE12: clear loads four, reads zero, zero ignored; at resolution 0 the readout here shows four after a clear
// RULE13: rc calibrates with crystal up, active/pm0
// RULE14: power modes one, two hold last calibration
// RULE15: event sets pending, masked cpu flag, mode gate
// RULE16: window restarts after each event, periodic wake
`timescale 1ns/1ps
`default_nettype none
module lpwt_timer #(
    parameter int CLK_FREQ  = lpwt_pkg::CLK_HZ,
    parameter int FREF_FREQ = lpwt_pkg::F_REF_HZ,
    parameter int RC_RAW    = lpwt_pkg::RC_RAW_HZ
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // link to the power-mode controller
    lpwt_if.dev                              lnk,
    // observation
    output logic [lpwt_pkg::CNT_W-1:0]       timer_count,
    output logic [lpwt_pkg::RATE_W-1:0]      rc_rate,
    output logic                             cal_active
);
    import lpwt_pkg::*;

    // ------------------------------------------------------------
    // slow clock sources
    // ------------------------------------------------------------

    localparam logic [RATE_W-1:0] XOSC_RATE = RATE_W'(XOSC_HZ);
    localparam logic [RATE_W-1:0] RC_TARGET = RATE_W'(FREF_FREQ / RC_DIV);
    localparam logic [RATE_W-1:0] RC_START  = RATE_W'(RC_RAW);

    logic [RATE_W-1:0] rc_q, rc_d;
    logic [RATE_W-1:0] src_rate;
    logic              tick;
    logic              cal_en;

    // calibration only while the crystal runs in active mode or pm0
    assign cal_en = lnk.xosc_run &&
                    (lnk.pmode == pm_active || lnk.pmode == power_mode_zero); // RULE13

    // rc trims one hz per cycle toward fref/750, else keeps last result
    always_comb begin
        rc_d = rc_q;
        if (cal_en) begin // RULE13
            if (rc_q < RC_TARGET) begin
                rc_d = rc_q + 16'h0001;
            end else if (rc_q > RC_TARGET) begin
                rc_d = rc_q - 16'h0001;
            end
        end
        // no branch for pm1/pm2: the held value is the last valid one
    end // RULE14

    always_ff @(posedge clk) begin
        if (srst) begin
            rc_q <= RC_START;
        end else begin
            rc_q <= rc_d;
        end
    end

    // source select; a change mid-period only shifts the next tick
    assign src_rate = lnk.osc_sel ? XOSC_RATE : rc_q; // RULE3

    lpwt_tick_gen #(
        .CLK_FREQ (CLK_FREQ)
    ) u_tick (
        .clk  (clk),
        .srst (srst),
        .rate (src_rate),
        .tick (tick)
    );

    // ------------------------------------------------------------
    // counter and compare
    // ------------------------------------------------------------

    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] span;
    logic             match;
    logic             in_sleep;

    assign cnt_inc = cnt_q + 31'h0000_0001;

    // the slice first equals the mantissa exactly at the full span
    assign span = lpwt_span(lnk.wake_compare_value, lnk.res); // RULE6

    assign in_sleep = (lnk.pmode == power_mode_zero) ||
                      (lnk.pmode == power_mode_one) ||
                      (lnk.pmode == power_mode_two);

    // clear beats the tick so software never sees a half-done clear
    always_comb begin
        cnt_d = cnt_q;
        match = 1'b0;
        if (lnk.cnt_clear) begin
            cnt_d = CNT_CLEAR_VAL; // RULE12
        end else if (tick) begin
            if (cnt_inc == span && span != '0) begin
                cnt_d = '0; // RULE16
                match = 1'b1; // RULE5
            end else begin
                cnt_d = cnt_inc; // RULE1
            end
        end
    end

    // clear lands the cycle after the strobe, well inside two edges
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d; // RULE11
        end
    end

    // ------------------------------------------------------------
    // events and flags
    // ------------------------------------------------------------

    logic        wake_q, wake_d;
    logic        pend_q, pend_d;
    logic        cpu_q, cpu_d;
    logic        tick_q;
    logic [15:0] time_q, time_d;

    // set wins over a clear arriving in the same cycle
    always_comb begin
        wake_d = match && in_sleep; // RULE4
        pend_d = (pend_q && !lnk.pend_clr) || match; // RULE15
        cpu_d  = (cpu_q && !lnk.cpu_clr) || (match && lnk.wake_irq_mask); // RULE15
        time_d = lpwt_slice(cnt_d, lnk.res); // RULE2
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wake_q <= 1'b0;
            pend_q <= 1'b0;
            cpu_q  <= 1'b0;
            tick_q <= 1'b0;
            time_q <= '0;
        end else begin
            wake_q <= wake_d;
            pend_q <= pend_d;
            cpu_q  <= cpu_d;
            tick_q <= tick;
            time_q <= time_d; // RULE9
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // readout changes only when the selected slice moves
    assign lnk.sleep_time         = time_q; // RULE9
    assign lnk.slow_tick          = tick_q;
    assign lnk.wake_req           = wake_q; // RULE5
    assign lnk.wake_pending_flag  = pend_q;
    assign lnk.sleep_cpu_irq_flag = cpu_q;

    assign timer_count = cnt_q;
    assign rc_rate     = rc_q;
    assign cal_active  = cal_en;

endmodule : lpwt_timer
`default_nettype wire

// >>> verilog/lpwt_pwr_ctrl.sv
// power-mode controller end with software registers
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lpwt_pwr_ctrl (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // link to the wake timer
    lpwt_if.pwr                       lnk,
    // software register port
    input  wire logic [2:0]           addr,
    input  wire logic [15:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic [15:0]               rdata,
    output logic                      irq,
    // chip side
    input  wire logic                 xosc_running,
    input  wire logic                 ext_wake,
    output lpwt_pkg::lpwt_pmode_t     power_mode
);
    import lpwt_pkg::*;

    lpwt_pmode_t pm_q, pm_d;
    logic [1:0]  res_q, res_d, smode_q, smode_d, guard_q, guard_d;
    logic        osc_q, osc_d, clr_q, clr_d, slp_q, slp_d, cp_q, cp_d;
    logic [15:0] cmp_q, cmp_d, cnew_q, cnew_d, rdata_q, rdata_d;
    logic [2:0]  mask_q, mask_d;
    logic        ref_q, ref_d;
    logic        wr_ctrl, wr_cmp, busy, apply;
    logic [30:0] rem;

    assign wr_ctrl = wr && addr == REG_CTRL;
    assign wr_cmp  = wr && addr == REG_CMP;
    assign busy    = guard_q < 2'(CLEAR_EDGES);
    // updates land on a slow edge once the clear has settled
    assign apply   = lnk.slow_tick && !busy; // RULE8 RULE11
    // periods left before the next event, from the visible slice
    assign rem = (cmp_q > lnk.sleep_time) ? lpwt_span(cmp_q - lnk.sleep_time, res_q) : '0;

    // ------------------------------------------------------------
    // control, compare and power state
    // ------------------------------------------------------------
    always_comb begin
        pm_d = pm_q; res_d = res_q; osc_d = osc_q; smode_d = smode_q;
        cmp_d = cmp_q; cnew_d = cnew_q; cp_d = cp_q; slp_d = slp_q;
        // a slow edge seen while the clear is still landing is not counted
        guard_d = (lnk.slow_tick && busy && !clr_q) ? guard_q + 2'h1 : guard_q; // RULE11
        clr_d = 1'b0;
        mask_d = (wr && addr == REG_MASK) ? wdata[2:0] : mask_q;
        ref_d = ref_q && !(wr && addr == REG_STAT && wdata[STAT_REF_BIT]);
        if (wr_ctrl) begin
            res_d   = wdata[CTRL_RES_LSB +: 2];
            osc_d   = wdata[CTRL_OSC_BIT];
            smode_d = wdata[CTRL_SMODE_LSB +: 2];
            slp_d   = slp_q || wdata[CTRL_SLEEP_BIT];
            clr_d   = wdata[CTRL_CLR_BIT]; // RULE12
        end
        if (wr_cmp) begin
            cnew_d = wdata;
            cp_d   = 1'b1;
            clr_d  = clr_d || (wdata < lnk.sleep_time); // RULE10
        end
        if (clr_d) begin
            guard_d = 2'h0; // RULE11
        end
        if (apply && cp_q) begin
            cmp_d = cnew_q;
            cp_d  = wr_cmp;
        end
        if (apply && slp_q && pm_q == pm_active && !cp_q) begin
            slp_d = 1'b0;
            case (smode_q)
                2'h0:    pm_d = power_mode_zero;
                2'h1:    pm_d = power_mode_one;
                2'h2: begin
                    if (rem < 31'(SLEEP_MIN_PER)) begin // RULE7
                        ref_d = 1'b1;
                    end else begin
                        pm_d = power_mode_two;
                    end
                end
                default: pm_d = power_mode_three;
            endcase
        end
        if (lnk.wake_req && pm_q != pm_active && pm_q != power_mode_three) begin
            pm_d = pm_active; // RULE5 RULE4
        end
        if (ext_wake) begin
            pm_d = pm_active;
        end
        rdata_d = 16'h0000;
        if (rd) begin
            case (addr)
                REG_CTRL: rdata_d = {8'h00, busy, slp_q, smode_q, 1'b0, osc_q, res_q};
                REG_CMP:  rdata_d = cmp_q;
                REG_TIME: rdata_d = lnk.sleep_time;
                REG_STAT: rdata_d = {13'h0000, ref_q, lnk.sleep_cpu_irq_flag,
                                     lnk.wake_pending_flag};
                REG_MASK: rdata_d = {13'h0000, mask_q};
                default:  rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pm_q <= pm_active; res_q <= RES_RESET; osc_q <= 1'b1; smode_q <= SMODE_RESET;
            cmp_q <= CMP_RESET; cnew_q <= CMP_RESET; cp_q <= 1'b0; slp_q <= 1'b0;
            guard_q <= 2'(CLEAR_EDGES); clr_q <= 1'b0; mask_q <= MASK_RESET;
            ref_q <= 1'b0; rdata_q <= 16'h0000;
        end else begin
            pm_q <= pm_d; res_q <= res_d; osc_q <= osc_d; smode_q <= smode_d;
            cmp_q <= cmp_d; cnew_q <= cnew_d; cp_q <= cp_d; slp_q <= slp_d;
            guard_q <= guard_d; clr_q <= clr_d; mask_q <= mask_d;
            ref_q <= ref_d; rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // link drive and interrupt
    // ------------------------------------------------------------
    assign lnk.pmode              = pm_q;
    assign lnk.wake_compare_value = cmp_q;
    assign lnk.res                = res_q;
    assign lnk.osc_sel            = osc_q;
    assign lnk.cnt_clear          = clr_q;
    assign lnk.xosc_run           = xosc_running;
    assign lnk.wake_irq_mask      = mask_q[STAT_CPU_BIT];
    assign lnk.pend_clr           = wr && addr == REG_STAT && wdata[STAT_PEND_BIT];
    assign lnk.cpu_clr            = wr && addr == REG_STAT && wdata[STAT_CPU_BIT];

    // cpu wake interrupt is blocked unless the sleep mode field is 00
    assign irq = (lnk.wake_pending_flag && mask_q[STAT_PEND_BIT]) ||
                 (ref_q && mask_q[STAT_REF_BIT]) ||
                 (lnk.sleep_cpu_irq_flag && smode_q == 2'h0); // RULE15
    assign rdata      = rdata_q;
    assign power_mode = pm_q;
endmodule : lpwt_pwr_ctrl
`default_nettype wire

// >>> bench/lpwt_monitor.sv
// assertion checker watching the link between timer and power controller
`timescale 1ns/1ps
`default_nettype none
module lpwt_monitor (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // controller to timer
    input  var  lpwt_pkg::lpwt_pmode_t pmode,
    input  wire logic [15:0]           wake_compare_value,
    input  wire logic [1:0]            res,
    input  wire logic                  cnt_clear,
    input  wire logic                  wake_irq_mask,
    input  wire logic                  pend_clr,
    // timer to controller
    input  wire logic [15:0]           sleep_time,
    input  wire logic                  slow_tick,
    input  wire logic                  wake_req,
    input  wire logic                  wake_pending_flag,
    input  wire logic                  sleep_cpu_irq_flag
);
    import lpwt_pkg::*;
    logic [1:0] guard_q;
    logic [1:0] guard_d;

    // ----------------------------------------------------------------
    // clear guard: slow edges since the last clear, saturating at two
    // ----------------------------------------------------------------
    always_comb begin
        guard_d = guard_q;
        if (cnt_clear) begin
            guard_d = 2'h0;
        end else if (slow_tick && guard_q != 2'h2) begin
            guard_d = guard_q + 2'h1;
        end
    end
    // reset counts as an old, finished clear
    always_ff @(posedge clk) begin
        guard_q <= srst ? 2'h2 : guard_d;
    end

    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (srst);

    a_clear_four: assert property (cnt_clear && res == 2'h0 |-> ##[1:2] sleep_time == 16'h0004)
        else $error("clear did not load four");
    a_guard_before_cmp: assert property ($changed(wake_compare_value) |-> guard_q == 2'h2)
        else $error("compare changed inside clear guard");
    a_cmp_on_tick: assert property ($changed(wake_compare_value) |-> $past(slow_tick) || $past(slow_tick, 2))
        else $error("compare changed off a slow edge");
    a_sleep_on_tick: assert property ($changed(pmode) && pmode != pm_active |-> $past(slow_tick) || $past(slow_tick, 2))
        else $error("sleep entered off a slow edge");
    a_no_wake_awake: assert property (pmode == pm_active || pmode == power_mode_three |=> !wake_req)
        else $error("wake request outside modes zero to two");
    a_wake_to_active: assert property (wake_req |=> pmode == pm_active && !wake_req)
        else $error("wake did not return to active");
    a_event_pending: assert property (wake_req |-> ##[0:1] wake_pending_flag)
        else $error("event did not set pending");
    a_cpu_flag_mask: assert property ($rose(sleep_cpu_irq_flag) |-> $past(wake_irq_mask) && wake_pending_flag)
        else $error("cpu flag set without mask or event");
    a_flag_sticky: assert property (wake_pending_flag && !pend_clr |=> wake_pending_flag)
        else $error("pending flag dropped without clear");
    a_tick_gap: assert property (slow_tick |=> !slow_tick [*8])
        else $error("slow ticks too close");
    a_wake_restarts: assert property (wake_req |-> ##[0:1] sleep_time == 16'h0000)
        else $error("window did not restart after event");
endmodule : lpwt_monitor
`default_nettype wire

// >>> bench/lpwt_tb_top.sv
// self-checking testbench joining timer and power controller
`timescale 1ns/1ps
`default_nettype none
module lpwt_tb_top;
    import lpwt_pkg::*;
    typedef struct packed { logic [1:0] res; logic [3:0] sh; } lpwt_row_t;
    // resolution beside the counter bit that lands in the readout lsb
    localparam lpwt_row_t ROWS [4] = '{'{2'h0, 4'h0}, '{2'h1, 4'h5}, '{2'h2, 4'ha}, '{2'h3, 4'hf}};
    logic        clk, srst, wr, rd, irq, xosc_running, ext_wake, cal_active;
    logic [2:0]  addr;
    logic [15:0] wdata, rdata, rc_rate, v, base;
    logic [30:0] count;
    lpwt_pmode_t power_mode;
    int          miscompares = 0, n_tests = 0, n_ticks = 0, w0, w1;

    lpwt_if u_lpwt_if ();
    // small clock figure keeps a slow period near fifteen cycles
    lpwt_timer #(.CLK_FREQ(500_000)) u_lpwt_timer (.clk(clk), .srst(srst), .lnk(u_lpwt_if),
        .timer_count(count), .rc_rate(rc_rate), .cal_active(cal_active));
    lpwt_pwr_ctrl u_lpwt_pwr_ctrl (.clk(clk), .srst(srst), .lnk(u_lpwt_if), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .xosc_running(xosc_running),
        .ext_wake(ext_wake), .power_mode(power_mode));
    lpwt_monitor u_lpwt_monitor (.clk(clk), .srst(srst), .pmode(u_lpwt_if.pmode),
        .wake_compare_value(u_lpwt_if.wake_compare_value), .res(u_lpwt_if.res),
        .cnt_clear(u_lpwt_if.cnt_clear), .wake_irq_mask(u_lpwt_if.wake_irq_mask),
        .pend_clr(u_lpwt_if.pend_clr), .sleep_time(u_lpwt_if.sleep_time),
        .slow_tick(u_lpwt_if.slow_tick), .wake_req(u_lpwt_if.wake_req),
        .wake_pending_flag(u_lpwt_if.wake_pending_flag),
        .sleep_cpu_irq_flag(u_lpwt_if.sleep_cpu_irq_flag));

    // ----------------------------------------------------------------
    // clock and slow-edge tally
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (u_lpwt_if.slow_tick === 1'b1) n_ticks <= n_ticks + 1;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic hang(input string name);
        miscompares++;
        $display("[FAIL] %s expected done seen timeout", name);
        close_out();
    endtask : hang
    // one-cycle strobes, changed just after an edge
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [2:0] a, input string name, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        if (name != "") chk(name, exp, v);
    endtask : rd_chk
    // leaves a quiet stretch of most of a slow period before the next tick
    task automatic wait_ticks(input int n);
        int c;
        int i;
        c = 0;
        for (i = 0; i < n * 40 && c < n; i++) begin
            @(posedge clk);
            #1;
            if (u_lpwt_if.slow_tick === 1'b1) c++;
        end
        if (c < n) hang("slow tick");
    endtask : wait_ticks
    task automatic wait_wake(output int t);
        int i;
        for (i = 0; i < 8000 && u_lpwt_if.wake_req !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        t = n_ticks;
        if (i == 8000) hang("wake");
    endtask : wait_wake

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        srst = 1'b1;
        addr = 3'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        xosc_running = 1'b1;
        ext_wake = 1'b0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        // slices of a counter grown past bit 10
        wait_ticks(1100);
        foreach (ROWS[i]) begin
            wait_ticks(1);
            wr_reg(REG_CTRL, 16'h0004);
            rd_chk(REG_TIME, "", 16'h0000);
            base = v;
            wr_reg(REG_CTRL, {14'h0001, ROWS[i].res});
            rd_chk(REG_TIME, "time slice", base >> ROWS[i].sh);
        end
        // second reset in mid-run, then reset values
        @(posedge clk);
        srst <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd_chk(REG_CTRL, "ctrl", 16'h0004);
        rd_chk(REG_CMP, "cmp", 16'h876b);
        rd_chk(REG_STAT, "stat", 16'h0000);
        rd_chk(REG_MASK, "mask", 16'h0000);
        rd_chk(3'h7, "unmapped", 16'h0000);
        chk("irq", 16'h0000, 16'(irq));
        // clear loads four, reads back four, busy for two slow edges
        wait_ticks(1);
        wr_reg(REG_CTRL, 16'h000c);
        rd_chk(REG_CTRL, "ctrl busy", 16'h0084);
        rd_chk(REG_TIME, "time clear", 16'h0004);
        chk("count clear", 16'h0004, count[15:0]);
        chk("count high", 16'h0000, 16'(count >> 16));
        wait_ticks(3);
        rd_chk(REG_CTRL, "ctrl idle", 16'h0004);
        // mantissa 3 at resolution 1 gives 96 slow periods
        wr_reg(REG_CTRL, 16'h0005);
        wr_reg(REG_CMP, 16'h0003);
        wait_ticks(2);
        rd_chk(REG_CMP, "cmp applied", 16'h0003);
        wr_reg(REG_MASK, 16'h0003);
        wr_reg(REG_CTRL, 16'h0045);
        wait_wake(w0);
        @(posedge clk);
        #1;
        chk("woken", 16'(pm_active), 16'(power_mode));
        rd_chk(REG_STAT, "stat event", 16'h0003);
        chk("irq event", 16'h0001, 16'(irq));
        wr_reg(REG_STAT, 16'h0003);
        wr_reg(REG_MASK, 16'h0000);
        rd_chk(REG_STAT, "stat cleared", 16'h0000);
        chk("irq cleared", 16'h0000, 16'(irq));
        chk("calibrating", 16'h0001, 16'(cal_active));
        wr_reg(REG_CTRL, 16'h0055);
        for (int i = 0; i < 200 && power_mode !== power_mode_one; i++) begin
            @(posedge clk);
            #1;
        end
        chk("in pm1", 16'(power_mode_one), 16'(power_mode));
        base = rc_rate;
        chk("cal held", 16'h0000, 16'(cal_active));
        repeat (20) @(posedge clk);
        #1;
        chk("rate held", base, rc_rate);
        wait_wake(w1);
        chk("interval", 16'h0060, 16'(w1 - w0));
        rd_chk(REG_STAT, "stat masked", 16'h0001);
        chk("irq masked", 16'h0000, 16'(irq));
        // deep sleep too close to the next event is refused
        wr_reg(REG_STAT, 16'h0001);
        wr_reg(REG_MASK, 16'h0004);
        wr_reg(REG_CTRL, 16'h0065);
        wait_ticks(3);
        chk("pm2 refused", 16'(pm_active), 16'(power_mode));
        rd_chk(REG_STAT, "stat refused", 16'h0004);
        chk("irq refused", 16'h0001, 16'(irq));
        // calibration stops once the crystal is down
        @(posedge clk);
        xosc_running <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("no crystal", 16'h0000, 16'(cal_active));
        close_out();
    end
endmodule : lpwt_tb_top
`default_nettype wire
